// ---- src/rtu_poller_regs.svh ----
// register map, field positions, reset values and timing for the input poller
// Overview of operation
// - block is a serial RTU master polling remote input modules on one port
// - up to three modules A, B, C share the bus, each configured apart
// - a module whose unit address is zero is unused and never polled
// - unit address ranges 0 to 247 and addresses each request to its module
// - per-module channel mask selects channels 0..7 or none; all eight are read, only those stored
// - per-channel input type, eight choices, default 4 to 20 mA
// - latest value of each active channel shown in tenths of a unit
// - per-channel status shows invalid or ok
`ifndef RTU_POLLER_REGS_SVH
`define RTU_POLLER_REGS_SVH

`define ADDR_W 6
`define REG_CTRL 6'h00
`define REG_IRQ_STAT 6'h01
`define REG_IRQ_MASK 6'h02
`define REG_MOD_CFG 6'h04
`define REG_MOD_TYPE 6'h08
`define REG_MOD_STAT 6'h0c
`define REG_VALUE 6'h10
`define NUM_VALUES 24

`define CTRL_EN_BIT 0
`define IRQ_DONE_BIT 0
`define IRQ_ERR_BIT 1
`define CFG_MODEL_BIT 8
`define CFG_MASK_LSB 16

`define UNIT_ADDR_MAX 8'hf7
`define TYPE_RST 24'h249249
`define FC_READ_INPUT 8'h04
`define FC_EXC_BIT 7
`define REQ_CH_COUNT 8'h08
`define RSP_BYTE_COUNT 8'h10
`define REQ_LEN 4'h8
`define RSP_LAST 5'h14
`define EXC_LAST 5'h04
`define CRC_INIT 16'hffff
`define CRC_POLY 16'ha001

`define CLK_HZ 50000000
`define BAUD_RATE 9600
`define RESP_TMO_MS 100
`define GAP_BITS 40

`endif

// ---- src/rtu_poller_pkg.sv ----
// types shared by the input poller
package rtu_poller_pkg;
    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_PICK = 3'b001,
        S_SEND = 3'b010,
        S_RECV = 3'b011,
        S_GAP = 3'b100
    } poll_state_type;
    typedef enum logic [2:0] {
        IN_BIPOLAR_20MA = 3'b000,
        IN_4_20MA = 3'b001,
        IN_TC_J = 3'b010,
        IN_TC_K = 3'b011,
        IN_TC_T = 3'b100,
        IN_TC_E = 3'b101,
        IN_TC_R = 3'b110,
        IN_TC_S = 3'b111
    } in_type_type;
endpackage

// ---- src/modbus_rtu_input_poller.sv ----
// serial RTU master polling up to three analogue input modules
//
// The implementer's own choices: the address map and the address-and-strobe port.
`include "rtu_poller_regs.svh"

module modbus_rtu_input_poller #(
    parameter int BIT_CYC = `CLK_HZ / `BAUD_RATE,
    parameter int TMO_CYC = (`CLK_HZ / 1000) * `RESP_TMO_MS,
    parameter int GAP_CYC = BIT_CYC * `GAP_BITS
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic [`ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic serial_rx,
    output logic serial_tx,
    output logic serial_tx_en,
    output logic irq
);
    rtu_poller_pkg::poll_state_type st_ff;
    logic en_ff, bad_ff, exc_ff, ok_ff, fail_ff, done_ff, skip_ff;
    logic rx_s1_ff, rx_s2_ff, rx_busy_ff, rx_vld_ff, tx_busy_ff, tx_start_ff, tx_ff;
    logic model_ff [3];
    logic [1:0] irq_stat_ff, irq_mask_ff, mod_ff;
    logic [2:0] tmp_ch;
    logic [3:0] rx_bit_ff, tx_bit_ff;
    logic [4:0] idx_ff, rsp_last;
    logic [7:0] uaddr_ff [3], chmask_ff [3], stat_ff [3];
    logic [7:0] rx_byte_ff, tx_byte_ff, req_byte;
    logic [8:0] rx_sh_ff;
    logic [9:0] tx_sh_ff;
    logic [15:0] crc_ff, val_ff [`NUM_VALUES], tmp_ff [8];
    logic [23:0] type_ff [3];
    logic [31:0] rdata_ff, rd_mux, tmr_ff, rx_cnt_ff, tx_cnt_ff;

    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        r = c ^ {8'h00, d};
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ `CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction

    // register writes
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            en_ff <= 1'b0;
            irq_mask_ff <= 2'h0;
            for (int m = 0; m < 3; m++) begin
                uaddr_ff[m] <= 8'h00;
                model_ff[m] <= 1'b0;
                chmask_ff[m] <= 8'h00;
                type_ff[m] <= `TYPE_RST;
            end
        end else if (reg_wr) begin
            if (reg_addr == `REG_CTRL) en_ff <= reg_wdata[`CTRL_EN_BIT];
            if (reg_addr == `REG_IRQ_MASK) irq_mask_ff <= reg_wdata[1:0];
            for (int m = 0; m < 3; m++) begin
                if (reg_addr == `REG_MOD_CFG + 6'(m)) begin
                    // out of range addresses are refused
                    if (reg_wdata[7:0] <= `UNIT_ADDR_MAX) uaddr_ff[m] <= reg_wdata[7:0];
                    model_ff[m] <= reg_wdata[`CFG_MODEL_BIT];
                    chmask_ff[m] <= reg_wdata[`CFG_MASK_LSB+:8];
                end
                if (reg_addr == `REG_MOD_TYPE + 6'(m)) type_ff[m] <= reg_wdata[23:0];
            end
        end
    end

    // sticky events, set wins over write-one-to-clear
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            irq_stat_ff <= 2'h0;
        end else begin
            for (int b = 0; b < 2; b++) begin
                if ((b == `IRQ_DONE_BIT && done_ff) || (b == `IRQ_ERR_BIT && fail_ff)) begin
                    irq_stat_ff[b] <= 1'b1;
                end else if (reg_wr && reg_addr == `REG_IRQ_STAT && reg_wdata[b]) begin
                    irq_stat_ff[b] <= 1'b0;
                end
            end
        end
    end
    assign irq = |(irq_stat_ff & irq_mask_ff);

    always_comb begin
        rd_mux = 32'h0;
        case (reg_addr)
            `REG_CTRL: rd_mux = {31'h0, en_ff};
            `REG_IRQ_STAT: rd_mux = {30'h0, irq_stat_ff};
            `REG_IRQ_MASK: rd_mux = {30'h0, irq_mask_ff};
            default: begin
                for (int m = 0; m < 3; m++) begin
                    if (reg_addr == `REG_MOD_CFG + 6'(m)) begin
                        rd_mux = {8'h0, chmask_ff[m], 7'h0, model_ff[m], uaddr_ff[m]};
                    end
                    if (reg_addr == `REG_MOD_TYPE + 6'(m)) rd_mux = {8'h0, type_ff[m]};
                    if (reg_addr == `REG_MOD_STAT + 6'(m)) rd_mux = {24'h0, stat_ff[m]};
                end
                for (int v = 0; v < `NUM_VALUES; v++) begin
                    if (reg_addr == `REG_VALUE + 6'(v)) rd_mux = {{16{val_ff[v][15]}}, val_ff[v]};
                end
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) rdata_ff <= 32'h0;
        else rdata_ff <= reg_rd ? rd_mux : 32'h0;
    end
    assign reg_rdata = rdata_ff;

    // transmitter, 8n1, driver enabled while shifting
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            tx_busy_ff <= 1'b0;
            tx_ff <= 1'b1;
            tx_sh_ff <= 10'h3ff;
            tx_bit_ff <= 4'h0;
            tx_cnt_ff <= 32'h0;
        end else if (tx_start_ff) begin
            tx_busy_ff <= 1'b1;
            tx_sh_ff <= {1'b1, tx_byte_ff, 1'b0};
            tx_bit_ff <= 4'h0;
            tx_cnt_ff <= 32'h0;
        end else if (tx_busy_ff) begin
            tx_ff <= tx_sh_ff[0];
            if (tx_cnt_ff == 32'(BIT_CYC - 1)) begin
                tx_cnt_ff <= 32'h0;
                tx_sh_ff <= {1'b1, tx_sh_ff[9:1]};
                tx_bit_ff <= tx_bit_ff + 4'h1;
                if (tx_bit_ff == 4'h9) tx_busy_ff <= 1'b0;
            end else begin
                tx_cnt_ff <= tx_cnt_ff + 32'h1;
            end
        end else begin
            tx_ff <= 1'b1;
        end
    end
    assign serial_tx = tx_ff;
    assign serial_tx_en = tx_busy_ff;

    // receiver, mid-bit sampling
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            rx_s1_ff <= 1'b1;
            rx_s2_ff <= 1'b1;
            rx_busy_ff <= 1'b0;
            rx_vld_ff <= 1'b0;
            rx_bit_ff <= 4'h0;
            rx_cnt_ff <= 32'h0;
            rx_sh_ff <= 9'h0;
            rx_byte_ff <= 8'h00;
        end else begin
            rx_s1_ff <= serial_rx;
            rx_s2_ff <= rx_s1_ff;
            rx_vld_ff <= 1'b0;
            if (!rx_busy_ff) begin
                if (!rx_s2_ff) begin
                    rx_busy_ff <= 1'b1;
                    rx_bit_ff <= 4'h0;
                    rx_cnt_ff <= 32'(BIT_CYC / 2);
                end
            end else if (rx_cnt_ff != 32'h0) begin
                rx_cnt_ff <= rx_cnt_ff - 32'h1;
            end else begin
                rx_cnt_ff <= 32'(BIT_CYC - 1);
                rx_bit_ff <= rx_bit_ff + 4'h1;
                rx_sh_ff <= {rx_s2_ff, rx_sh_ff[8:1]};
                if (rx_bit_ff == 4'h0 && rx_s2_ff) rx_busy_ff <= 1'b0;
                if (rx_bit_ff == 4'h9) begin
                    rx_busy_ff <= 1'b0;
                    rx_vld_ff <= rx_s2_ff;
                    rx_byte_ff <= rx_sh_ff[8:1];
                end
            end
        end
    end

    always_comb begin
        case (idx_ff[3:0])
            4'h0: req_byte = uaddr_ff[mod_ff];
            4'h1: req_byte = `FC_READ_INPUT;
            4'h5: req_byte = `REQ_CH_COUNT;
            4'h6: req_byte = crc_ff[7:0];
            4'h7: req_byte = crc_ff[15:8];
            default: req_byte = 8'h00;
        endcase
    end
    assign rsp_last = exc_ff ? `EXC_LAST : `RSP_LAST;
    assign tmp_ch = 3'((idx_ff - 5'h3) >> 1);

    // poll sequencer
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            st_ff <= rtu_poller_pkg::S_IDLE;
            mod_ff <= 2'h0;
            idx_ff <= 5'h0;
            crc_ff <= `CRC_INIT;
            tmr_ff <= 32'h0;
            bad_ff <= 1'b0;
            exc_ff <= 1'b0;
            ok_ff <= 1'b0;
            fail_ff <= 1'b0;
            done_ff <= 1'b0;
            skip_ff <= 1'b0;
            tx_start_ff <= 1'b0;
            tx_byte_ff <= 8'h00;
            for (int c = 0; c < 8; c++) tmp_ff[c] <= 16'h0;
        end else begin
            ok_ff <= 1'b0;
            fail_ff <= 1'b0;
            done_ff <= 1'b0;
            skip_ff <= 1'b0;
            tx_start_ff <= 1'b0;
            case (st_ff)
                rtu_poller_pkg::S_IDLE: begin
                    mod_ff <= 2'h0;
                    if (en_ff) st_ff <= rtu_poller_pkg::S_PICK;
                end
                rtu_poller_pkg::S_PICK: begin
                    idx_ff <= 5'h0;
                    crc_ff <= `CRC_INIT;
                    if (mod_ff == 2'h3) begin
                        done_ff <= 1'b1;
                        st_ff <= rtu_poller_pkg::S_IDLE;
                    end else if (uaddr_ff[mod_ff] == 8'h00) begin
                        // hold one cycle so the status clear lands on this module
                        skip_ff <= !skip_ff;
                        if (skip_ff) mod_ff <= mod_ff + 2'h1;
                    end else begin
                        st_ff <= rtu_poller_pkg::S_SEND;
                    end
                end
                rtu_poller_pkg::S_SEND: begin
                    if (!tx_busy_ff && !tx_start_ff) begin
                        if (idx_ff[3:0] == `REQ_LEN) begin
                            st_ff <= rtu_poller_pkg::S_RECV;
                            idx_ff <= 5'h0;
                            crc_ff <= `CRC_INIT;
                            tmr_ff <= 32'h0;
                            bad_ff <= 1'b0;
                            exc_ff <= 1'b0;
                        end else begin
                            tx_byte_ff <= req_byte;
                            tx_start_ff <= 1'b1;
                            if (idx_ff < 5'h6) crc_ff <= crc_step(crc_ff, req_byte);
                            idx_ff <= idx_ff + 5'h1;
                        end
                    end
                end
                rtu_poller_pkg::S_RECV: begin
                    tmr_ff <= tmr_ff + 32'h1;
                    if (rx_vld_ff) begin
                        crc_ff <= crc_step(crc_ff, rx_byte_ff);
                        idx_ff <= idx_ff + 5'h1;
                        tmr_ff <= 32'h0;
                        if (idx_ff == 5'h0 && rx_byte_ff != uaddr_ff[mod_ff]) bad_ff <= 1'b1;
                        if (idx_ff == 5'h1) begin
                            if (rx_byte_ff[`FC_EXC_BIT]) exc_ff <= 1'b1;
                            else if (rx_byte_ff != `FC_READ_INPUT) bad_ff <= 1'b1;
                        end
                        if (idx_ff == 5'h2 && !exc_ff && rx_byte_ff != `RSP_BYTE_COUNT) bad_ff <= 1'b1;
                        if (idx_ff >= 5'h3 && idx_ff < 5'h13 && !exc_ff) begin
                            if (idx_ff[0]) tmp_ff[tmp_ch][15:8] <= rx_byte_ff;
                            else tmp_ff[tmp_ch][7:0] <= rx_byte_ff;
                        end
                        if (idx_ff == rsp_last) begin
                            // residue of zero means checksum good
                            if (crc_step(crc_ff, rx_byte_ff) == 16'h0 && !bad_ff && !exc_ff) ok_ff <= 1'b1;
                            else fail_ff <= 1'b1;
                            st_ff <= rtu_poller_pkg::S_GAP;
                            tmr_ff <= 32'h0;
                        end
                    end else if (tmr_ff == 32'(TMO_CYC - 1)) begin
                        fail_ff <= 1'b1;
                        st_ff <= rtu_poller_pkg::S_GAP;
                        tmr_ff <= 32'h0;
                    end
                end
                rtu_poller_pkg::S_GAP: begin
                    // idle line between frames, then next module in order
                    tmr_ff <= tmr_ff + 32'h1;
                    if (tmr_ff == 32'(GAP_CYC - 1)) begin
                        mod_ff <= mod_ff + 2'h1;
                        st_ff <= rtu_poller_pkg::S_PICK;
                    end
                end
                default: st_ff <= rtu_poller_pkg::S_IDLE;
            endcase
        end
    end

    // channel values and status
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            for (int m = 0; m < 3; m++) stat_ff[m] <= 8'h00;
            for (int v = 0; v < `NUM_VALUES; v++) val_ff[v] <= 16'h0;
        end else if (ok_ff) begin
            stat_ff[mod_ff] <= chmask_ff[mod_ff];
            for (int c = 0; c < 8; c++) begin
                if (chmask_ff[mod_ff][c]) val_ff[5'(mod_ff) * 5'h8 + 5'(c)] <= tmp_ff[c];
            end
        end else if (fail_ff || skip_ff) begin
            stat_ff[mod_ff] <= 8'h00;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    a_unused_skip: assert property (st_ff == rtu_poller_pkg::S_SEND |-> uaddr_ff[mod_ff] != 8'h00)
        else $error("unused module polled");
    a_addr_range: assert property (uaddr_ff[0] <= `UNIT_ADDR_MAX && uaddr_ff[1] <= `UNIT_ADDR_MAX)
        else $error("unit address out of range");
    a_module_count: assert property (st_ff == rtu_poller_pkg::S_RECV |-> mod_ff < 2'h3)
        else $error("module index beyond three");
    a_fail_invalid: assert property (fail_ff |=> stat_ff[mod_ff] == 8'h00)
        else $error("failed module still shows ok");
    a_ok_status: assert property (ok_ff |=> stat_ff[mod_ff] == $past(chmask_ff[mod_ff]))
        else $error("status differs from channel mask");
    a_value_load: assert property (ok_ff && chmask_ff[0][0] && mod_ff == 2'h0 |=> val_ff[0] == $past(tmp_ff[0]))
        else $error("channel value not loaded");
    a_wait_answer: assert property (st_ff == rtu_poller_pkg::S_RECV && !rx_vld_ff && tmr_ff < 32'(TMO_CYC - 1)
        |=> st_ff == rtu_poller_pkg::S_RECV)
        else $error("left receive before answer or timeout");
    a_type_reset: assert property ($rose(reset_n) |-> type_ff[0] == `TYPE_RST && type_ff[2] == `TYPE_RST)
        else $error("input type not at default");
    a_tx_idle: assert property (!serial_tx_en |=> serial_tx)
        else $error("line not idle high");
    a_skip_clear: assert property (skip_ff && mod_ff == 2'h2 |=> stat_ff[2] == 8'h00)
        else $error("unused module status not cleared");

    c_good_reply: cover property (ok_ff);
    c_bad_reply: cover property (fail_ff);
    c_cycle_done: cover property (done_ff ##1 irq);
endmodule // modbus_rtu_input_poller

// ---- verif/rtu_slave_model.sv ----
// behavioural pair of remote input modules answering on the serial line
module rtu_slave_model #(
    parameter int BIT_CYC = 8,
    parameter logic [7:0] UNIT0 = 8'h05,
    parameter logic [7:0] UNIT1 = 8'hf7
) (
    input wire logic mclk,
    input wire logic line_in,
    input wire logic [2:0] mode,
    output logic line_out,
    output logic req_bad
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] seen[$];
    logic [7:0] req[8];
    logic [7:0] rsp[$];
    logic [15:0] crc;

    function automatic logic [15:0] crc16(input logic [7:0] b[$]);
        logic [15:0] c;
        c = 16'hffff;
        foreach (b[i]) begin
            c ^= {8'h00, b[i]};
            for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
        end
        return c;
    endfunction

    task automatic get_byte(output logic [7:0] d);
        @(negedge line_in);
        repeat (BIT_CYC / 2) @(posedge mclk);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT_CYC) @(posedge mclk);
            d[i] = line_in;
        end
        repeat (BIT_CYC) @(posedge mclk);
    endtask

    task automatic put_byte(input logic [7:0] d);
        logic [9:0] f;
        f = {1'b1, d, 1'b0};
        for (int i = 0; i < 10; i++) begin
            line_out <= f[i];
            repeat (BIT_CYC) @(posedge mclk);
        end
    endtask

    // mode: 0 good, 1 bad checksum, 2 silent, 3 exception, 4 slow
    initial begin
        line_out = 1'b1;
        req_bad = 1'b0;
        forever begin
            foreach (req[i]) get_byte(req[i]);
            seen.push_back(req[0]);
            rsp = '{req[0], req[1], req[2], req[3], req[4], req[5]};
            if ({req[1], req[2], req[3], req[4], req[5], req[7], req[6]} !== {8'h04, 32'h8, crc16(rsp)}) req_bad = 1'b1;
            if ((req[0] == UNIT0 || req[0] == UNIT1) && mode != 3'd2) begin
                if (mode == 3'd3) begin
                    rsp = '{req[0], 8'h84, 8'h02};
                end else begin
                    rsp = '{req[0], 8'h04, 8'h10};
                    for (int ch = 0; ch < 8; ch++) begin
                        rsp.push_back({4'hf, req[0][7:4]});
                        rsp.push_back({req[0][3:0], 4'(ch)});
                    end
                end
                crc = crc16(rsp);
                rsp.push_back(crc[7:0] ^ {7'h00, mode == 3'd1});
                rsp.push_back(crc[15:8]);
                repeat (mode == 3'd4 ? 300 : 2 * BIT_CYC) @(posedge mclk);
                foreach (rsp[i]) put_byte(rsp[i]);
            end
        end
    end
endmodule // rtu_slave_model

// ---- verif/modbus_rtu_input_poller_test.sv ----
// self-checking bench for the input poller
`include "rtu_poller_regs.svh"
`define CHECK(what, exp, got) \
    begin \
        tests_run++; \
        if ((got) !== (exp)) begin \
            num_errors++; \
            $display("unexpected %s: expected %h, seen %h", what, exp, got); \
        end \
    end

module modbus_rtu_input_poller_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic [`ADDR_W-1:0] reg_addr = '0;
    logic [31:0] reg_wdata = '0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic serial_rx;
    logic serial_tx;
    logic serial_tx_en;
    logic irq;
    logic bus_line;
    logic req_bad;
    logic [2:0] mode = 3'd0;
    logic [2:0] modes[6] = '{3'd0, 3'd1, 3'd4, 3'd2, 3'd0, 3'd3};
    int num_errors = 0;
    int tests_run = 0;

    always #10 mclk = ~mclk;
    // released driver leaves the biased line high
    assign bus_line = serial_tx_en ? serial_tx : 1'b1;

    modbus_rtu_input_poller #(.BIT_CYC(8), .TMO_CYC(400), .GAP_CYC(80)) i_modbus_rtu_input_poller (
        .mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .serial_rx(serial_rx), .serial_tx(serial_tx),
        .serial_tx_en(serial_tx_en), .irq(irq));
    rtu_slave_model #(.BIT_CYC(8)) i_rtu_slave_model (
        .mclk(mclk), .line_in(bus_line), .mode(mode), .line_out(serial_rx), .req_bad(req_bad));

    task automatic results();
        if (num_errors == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic wr(input logic [`ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [`ADDR_W-1:0] a, input logic [31:0] exp, input string what);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        `CHECK(what, exp, reg_rdata)
    endtask

    // one full poll cycle, then stop and let a restarted cycle drain
    task automatic run_poll(input logic [2:0] m);
        int n;
        mode <= m;
        wr(`REG_IRQ_STAT, 32'h3);
        wr(`REG_CTRL, 32'h1);
        n = 0;
        while (irq !== 1'b1 && n < 20000) begin
            @(posedge mclk);
            n++;
        end
        `CHECK("poll done", 1'b1, irq)
        wr(`REG_CTRL, 32'h0);
        repeat (6000) @(posedge mclk);
    endtask

    initial begin
        logic [7:0] u;
        logic [31:0] exp;
        logic ok;
        repeat (4) @(posedge mclk);
        reset_n <= 1'b1;
        #1;
        `CHECK("line idle", 2'b10, {serial_tx, serial_tx_en})
        rd(`REG_CTRL, 32'h0, "ctrl");
        rd(`REG_MOD_CFG, 32'h0, "cfg a");
        rd(`REG_MOD_TYPE + 6'h2, `TYPE_RST, "type reset");
        rd(`REG_MOD_STAT, 32'h0, "stat a");
        rd(`REG_VALUE, 32'h0, "value");
        rd(6'h03, 32'h0, "unmapped");
        wr(`REG_MOD_CFG, 32'h00ff01f8);
        rd(`REG_MOD_CFG, 32'h00ff0100, "cfg over range");
        wr(`REG_MOD_TYPE, 32'h00fac688);
        rd(`REG_MOD_TYPE, 32'h00fac688, "types");
        wr(`REG_MOD_CFG, 32'h00ff0005);
        wr(`REG_MOD_CFG + 6'h2, 32'h000500f7);
        wr(`REG_IRQ_MASK, 32'h1);
        run_poll(3'd0);
        `CHECK("poll order", 16'h05f7, {i_rtu_slave_model.seen[0], i_rtu_slave_model.seen[1]})
        `CHECK("request form", 1'b0, req_bad)
        for (int i = 0; i < 24; i++) begin
            u = (i < 8) ? 8'h05 : 8'hf7;
            exp = (i < 8 || i == 16 || i == 18) ? {20'hfffff, u, 4'(i % 8)} : 32'h0;
            rd(`REG_VALUE + 6'(i), exp, "value");
        end
        rd(`REG_MOD_STAT, 32'hff, "stat a");
        rd(`REG_MOD_STAT + 6'h1, 32'h0, "stat b");
        rd(`REG_MOD_STAT + 6'h2, 32'h05, "stat c");
        wr(`REG_MOD_CFG + 6'h2, 32'h0);
        foreach (modes[k]) begin
            run_poll(modes[k]);
            ok = modes[k] == 3'd0 || modes[k] == 3'd4;
            rd(`REG_MOD_STAT, ok ? 32'hff : 32'h0, "stat a");
            rd(`REG_IRQ_STAT, ok ? 32'h1 : 32'h3, "irq stat");
            rd(`REG_VALUE + 6'h7, 32'hfffff057, "value kept");
        end
        rd(`REG_MOD_STAT + 6'h2, 32'h0, "stat c unused");
        wr(`REG_IRQ_MASK, 32'h0);
        `CHECK("irq masked", 1'b0, irq)
        wr(`REG_IRQ_MASK, 32'h2);
        `CHECK("irq error", 1'b1, irq)
        wr(`REG_IRQ_STAT, 32'h2);
        `CHECK("irq cleared", 1'b0, irq)
        results();
    end

    initial begin
        repeat (100000) @(posedge mclk);
        num_errors++;
        results();
    end
endmodule // modbus_rtu_input_poller_test
